// ### bpa_dev_end.sv
module bpa_dev_end (
   input  wire logic                       clk,
   input  wire logic                       resetn,
   bpa_bus_if.dev_mp                       bus,
   input  wire logic                       internal_busy,
   input  wire logic                       drive_req,
   input  wire logic                       drive_as_slave,
   input  wire logic [bpa_pkg::DATA_W-1:0] drive_data,
   output logic [1:0]                      owner,
   output logic [bpa_pkg::CNT_W-1:0]       grant_count,
   output logic [bpa_pkg::DATA_W-1:0]      rx_data,
   output logic                            rx_valid,
   output logic [bpa_pkg::LANES-1:0]       parity_err,
   output logic                            drive_refused
);
   // ==========================================================
   // request sampling
   logic                       req_two;
   logic                       req_three;

   // requests are taken as synchronous to clk
   assign req_two   = bus.outside_master_request_two;
   assign req_three = bus.outside_master_request_three;

   // ==========================================================
   // arbiter state
   bpa_pkg::bpa_own_t          own_ff, nxt_own;
   logic                       last_three_ff, nxt_last_three;
   logic                       bg_two_ff, nxt_bg_two;
   logic                       bg_three_ff, nxt_bg_three;
   logic                       dbg_two_ff, nxt_dbg_two;
   logic                       dbg_three_ff, nxt_dbg_three;
   logic [bpa_pkg::CNT_W-1:0]  gcnt_ff, nxt_gcnt;

   // a new tenure is started only while the internal side is idle;
   // with both requests up the winner alternates so neither starves
   always_comb begin
      nxt_own        = own_ff;
      nxt_last_three = last_three_ff;
      unique case (own_ff)
         bpa_pkg::BPA_OWN_NONE: begin
            if (!internal_busy) begin
               if (req_two && req_three) begin
                  nxt_own = last_three_ff ? bpa_pkg::BPA_OWN_TWO
                                          : bpa_pkg::BPA_OWN_THREE;
               end else if (req_two) begin
                  nxt_own = bpa_pkg::BPA_OWN_TWO;
               end else if (req_three) begin
                  nxt_own = bpa_pkg::BPA_OWN_THREE;
               end
            end
            if (nxt_own == bpa_pkg::BPA_OWN_THREE) begin
               nxt_last_three = 1'b1;
            end else if (nxt_own == bpa_pkg::BPA_OWN_TWO) begin
               nxt_last_three = 1'b0;
            end
         end
         bpa_pkg::BPA_OWN_TWO: begin
            // tenure ends when the owner withdraws its request
            if (!req_two) begin
               nxt_own = bpa_pkg::BPA_OWN_NONE;
            end
         end
         bpa_pkg::BPA_OWN_THREE: begin
            if (!req_three) begin
               nxt_own = bpa_pkg::BPA_OWN_NONE;
            end
         end
         default: begin
            nxt_own = bpa_pkg::BPA_OWN_NONE;
         end
      endcase
   end

   // ==========================================================
   // grant pins
   // the address grant follows ownership at once; the data grant
   // rises one cycle after it so the old data driver can let go; both drop on the same edge
   always_comb begin
      nxt_bg_two    = (nxt_own == bpa_pkg::BPA_OWN_TWO);
      nxt_bg_three  = (nxt_own == bpa_pkg::BPA_OWN_THREE);
      nxt_dbg_two   = (own_ff == bpa_pkg::BPA_OWN_TWO)
                      && (nxt_own == bpa_pkg::BPA_OWN_TWO);
      nxt_dbg_three = (own_ff == bpa_pkg::BPA_OWN_THREE)
                      && (nxt_own == bpa_pkg::BPA_OWN_THREE);
      nxt_gcnt      = gcnt_ff;
      if ((own_ff == bpa_pkg::BPA_OWN_NONE)
          && (nxt_own != bpa_pkg::BPA_OWN_NONE)) begin
         // wraps; only a rough activity figure
         nxt_gcnt = gcnt_ff + bpa_pkg::CNT_ONE;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         own_ff        <= bpa_pkg::BPA_OWN_NONE;
         last_three_ff <= 1'b0;
         bg_two_ff     <= 1'b0;
         bg_three_ff   <= 1'b0;
         dbg_two_ff    <= 1'b0;
         dbg_three_ff  <= 1'b0;
         gcnt_ff       <= bpa_pkg::CNT_RST;
      end else begin
         own_ff        <= nxt_own;
         last_three_ff <= nxt_last_three;
         bg_two_ff     <= nxt_bg_two;
         bg_three_ff   <= nxt_bg_three;
         dbg_two_ff    <= nxt_dbg_two;
         dbg_three_ff  <= nxt_dbg_three;
         gcnt_ff       <= nxt_gcnt;
      end
   end

   // single state register means at most one owner
   assign bus.outside_master_grant_two   = bg_two_ff;
   assign bus.outside_master_grant_three = bg_three_ff;
   assign bus.outside_data_grant_two     = dbg_two_ff;
   assign bus.outside_data_grant_three   = dbg_three_ff;
   assign grant_count                    = gcnt_ff;

   // ==========================================================
   // data and parity drive
   logic [bpa_pkg::DATA_W-1:0] d_ff, nxt_d;
   logic [bpa_pkg::LANES-1:0]  p_ff, nxt_p;
   logic                       oe_ff, nxt_oe;
   logic                       refused_ff, nxt_refused;
   logic                       ext_data_owner;
   logic                       drive_ok;

   assign ext_data_owner = dbg_two_ff | dbg_three_ff;
   // master writes only while no outside data grant stands,
   // slave replies only while one does
   assign drive_ok = drive_as_slave == ext_data_owner;

   always_comb begin
      nxt_oe      = drive_req & drive_ok;
      nxt_refused = drive_req & ~drive_ok;
      nxt_d       = drive_data;
   end

   // parity is formed from the same word that goes out, so the
   // two can never be a cycle apart
   for (genvar g = 0; g < bpa_pkg::LANES; g++) begin : g_par
      assign nxt_p[g] = bpa_pkg::bpa_odd_par(
         drive_data[g*bpa_pkg::LANE_W +: bpa_pkg::LANE_W]);
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         d_ff       <= bpa_pkg::DATA_RST;
         p_ff       <= bpa_pkg::PAR_RST;
         oe_ff      <= 1'b0;
         refused_ff <= 1'b0;
      end else begin
         d_ff       <= nxt_d;
         p_ff       <= nxt_p;
         oe_ff      <= nxt_oe;
         refused_ff <= nxt_refused;
      end
   end

   assign bus.dev_d    = d_ff;
   assign bus.dev_p    = p_ff;
   assign bus.dev_d_oe = oe_ff;
   assign bus.dev_p_oe = oe_ff;
   assign drive_refused = refused_ff;

   // ==========================================================
   // receive and lane check
   logic [bpa_pkg::DATA_W-1:0] rx_ff, nxt_rx;
   logic                       rxv_ff, nxt_rxv;
   logic [bpa_pkg::LANES-1:0]  err_ff, nxt_err;
   logic                       ext_drives;

   // parity is only judged while the outside party drives both
   assign ext_drives = bus.ext_d_oe & bus.ext_p_oe;

   always_comb begin
      nxt_rxv = ext_drives;
      nxt_rx  = ext_drives ? bus.bus_d : rx_ff;
   end

   for (genvar g = 0; g < bpa_pkg::LANES; g++) begin : g_chk
      assign nxt_err[g] = ext_drives & bpa_pkg::bpa_par_bad(
         bus.bus_d[g*bpa_pkg::LANE_W +: bpa_pkg::LANE_W],
         bus.bus_p[g]);
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rx_ff  <= bpa_pkg::DATA_RST;
         rxv_ff <= 1'b0;
         err_ff <= bpa_pkg::PAR_RST;
      end else begin
         rx_ff  <= nxt_rx;
         rxv_ff <= nxt_rxv;
         err_ff <= nxt_err;
      end
   end

   assign rx_data    = rx_ff;
   assign rx_valid   = rxv_ff;
   assign parity_err = err_ff;

   // ==========================================================
   // owner view
   logic [1:0]                 owner_ff, nxt_owner;

   always_comb begin
      unique case (nxt_own)
         bpa_pkg::BPA_OWN_TWO:   nxt_owner = 2'h2;
         bpa_pkg::BPA_OWN_THREE: nxt_owner = 2'h3;
         default:                nxt_owner = 2'h0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         owner_ff <= 2'h0;
      end else begin
         owner_ff <= nxt_owner;
      end
   end

   // matches the address grant pins cycle for cycle
   assign owner = owner_ff;
endmodule : bpa_dev_end

// ### bpa_pkg.sv
package bpa_pkg;
   // ==========================================================
   // bus geometry
   localparam int unsigned DATA_W  = 64;
   localparam int unsigned LANE_W  = 8;
   localparam int unsigned LANES   = 6;
   localparam int unsigned CNT_W   = 16;

   // ==========================================================
   // reset values
   localparam logic [DATA_W-1:0] DATA_RST   = 64'h0;
   localparam logic [LANES-1:0]  PAR_RST    = 6'h0;
   localparam logic [CNT_W-1:0]  CNT_RST    = 16'h0;
   localparam logic [CNT_W-1:0]  CNT_ONE    = 16'h1;

   // ==========================================================
   // arbiter ownership
   typedef enum logic [1:0] {
      BPA_OWN_NONE,
      BPA_OWN_TWO,
      BPA_OWN_THREE
   } bpa_own_t;

   // odd parity bit for one byte lane
   function automatic logic bpa_odd_par(input logic [LANE_W-1:0] lane);
      bpa_odd_par = ~(^lane);
   endfunction : bpa_odd_par

   // high when lane plus parity bit holds an even count of ones
   function automatic logic bpa_par_bad(input logic [LANE_W-1:0] lane,
                                        input logic              par);
      bpa_par_bad = ~(^{par, lane});
   endfunction : bpa_par_bad
endpackage : bpa_pkg

// ### bpa_bus_if.sv
interface bpa_bus_if;
   // ==========================================================
   // per-party drivers of data and parity
   logic [bpa_pkg::DATA_W-1:0] dev_d;
   logic                       dev_d_oe;
   logic [bpa_pkg::LANES-1:0]  dev_p;
   logic                       dev_p_oe;
   logic [bpa_pkg::DATA_W-1:0] ext_d;
   logic                       ext_d_oe;
   logic [bpa_pkg::LANES-1:0]  ext_p;
   logic                       ext_p_oe;

   // ==========================================================
   // arbitration pins
   logic                       outside_master_request_two;
   logic                       outside_master_request_three;
   logic                       outside_master_grant_two;
   logic                       outside_master_grant_three;
   logic                       outside_data_grant_two;
   logic                       outside_data_grant_three;

   // ==========================================================
   // resolved wire levels, idle bus reads as zero
   logic [bpa_pkg::DATA_W-1:0] bus_d;
   logic [bpa_pkg::LANES-1:0]  bus_p;

   assign bus_d = dev_d_oe ? dev_d : (ext_d_oe ? ext_d : '0);
   assign bus_p = dev_p_oe ? dev_p : (ext_p_oe ? ext_p : '0);

   modport dev_mp (
      output dev_d, dev_d_oe, dev_p, dev_p_oe,
      output outside_master_grant_two, outside_master_grant_three,
      output outside_data_grant_two, outside_data_grant_three,
      input  ext_d_oe, ext_p_oe, bus_d, bus_p,
      input  outside_master_request_two, outside_master_request_three
   );

   modport ext_mp (
      output ext_d, ext_d_oe, ext_p, ext_p_oe,
      output outside_master_request_two, outside_master_request_three,
      input  dev_d_oe, dev_p_oe, bus_d, bus_p,
      input  outside_master_grant_two, outside_master_grant_three,
      input  outside_data_grant_two, outside_data_grant_three
   );
endinterface : bpa_bus_if

// ### bpa_ext_end.sv
module bpa_ext_end (
   input  wire logic                       clk,
   input  wire logic                       resetn,
   bpa_bus_if.ext_mp                       bus,
   input  wire logic                       want_two,
   input  wire logic                       want_three,
   input  wire logic                       drive_req,
   input  wire logic                       drive_as_slave,
   input  wire logic [bpa_pkg::DATA_W-1:0] drive_data,
   output logic                            granted_two,
   output logic                            granted_three,
   output logic [bpa_pkg::DATA_W-1:0]      rx_data,
   output logic                            rx_valid,
   output logic [bpa_pkg::LANES-1:0]       parity_err
);
   // ==========================================================
   // requests and grant view
   logic                       req_two_ff, nxt_req_two;
   logic                       req_three_ff, nxt_req_three;
   logic                       gnt_two_ff, nxt_gnt_two;
   logic                       gnt_three_ff, nxt_gnt_three;

   always_comb begin
      nxt_req_two   = want_two;
      nxt_req_three = want_three;
      nxt_gnt_two   = bus.outside_master_grant_two
                      & bus.outside_data_grant_two;
      nxt_gnt_three = bus.outside_master_grant_three
                      & bus.outside_data_grant_three;
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         req_two_ff   <= 1'b0;
         req_three_ff <= 1'b0;
         gnt_two_ff   <= 1'b0;
         gnt_three_ff <= 1'b0;
      end else begin
         req_two_ff   <= nxt_req_two;
         req_three_ff <= nxt_req_three;
         gnt_two_ff   <= nxt_gnt_two;
         gnt_three_ff <= nxt_gnt_three;
      end
   end

   assign bus.outside_master_request_two   = req_two_ff;
   assign bus.outside_master_request_three = req_three_ff;
   assign granted_two   = gnt_two_ff;
   assign granted_three = gnt_three_ff;

   // ==========================================================
   // data and parity drive
   logic [bpa_pkg::DATA_W-1:0] d_ff, nxt_d;
   logic [bpa_pkg::LANES-1:0]  p_ff, nxt_p;
   logic                       oe_ff, nxt_oe;
   logic                       dgnt;

   assign dgnt = bus.outside_data_grant_two | bus.outside_data_grant_three;

   always_comb begin
      // as master only under a data grant, as slave only outside one
      nxt_oe = drive_req & (drive_as_slave ^ dgnt);
      nxt_d  = drive_data;
      for (int i = 0; i < bpa_pkg::LANES; i++) begin
         nxt_p[i] = bpa_pkg::bpa_odd_par(
                       drive_data[i*bpa_pkg::LANE_W +: bpa_pkg::LANE_W]);
      end
   end

   // ==========================================================
   // receive and lane check
   logic [bpa_pkg::DATA_W-1:0] rx_ff, nxt_rx;
   logic                       rxv_ff, nxt_rxv;
   logic [bpa_pkg::LANES-1:0]  err_ff, nxt_err;

   always_comb begin
      nxt_rxv = bus.dev_d_oe;
      nxt_rx  = bus.dev_d_oe ? bus.bus_d : rx_ff;
      for (int i = 0; i < bpa_pkg::LANES; i++) begin
         nxt_err[i] = bus.dev_d_oe & bpa_pkg::bpa_par_bad(
                         bus.bus_d[i*bpa_pkg::LANE_W +: bpa_pkg::LANE_W],
                         bus.bus_p[i]);
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         d_ff   <= bpa_pkg::DATA_RST;
         p_ff   <= bpa_pkg::PAR_RST;
         oe_ff  <= 1'b0;
         rx_ff  <= bpa_pkg::DATA_RST;
         rxv_ff <= 1'b0;
         err_ff <= bpa_pkg::PAR_RST;
      end else begin
         d_ff   <= nxt_d;
         p_ff   <= nxt_p;
         oe_ff  <= nxt_oe;
         rx_ff  <= nxt_rx;
         rxv_ff <= nxt_rxv;
         err_ff <= nxt_err;
      end
   end

   assign bus.ext_d    = d_ff;
   assign bus.ext_p    = p_ff;
   assign bus.ext_d_oe = oe_ff;
   assign bus.ext_p_oe = oe_ff;
   assign rx_data      = rx_ff;
   assign rx_valid     = rxv_ff;
   assign parity_err   = err_ff;
endmodule : bpa_ext_end

// ### bpa_chk.sv
module bpa_chk (
   input logic                       clk,
   input logic                       resetn,
   input logic                       dev_d_oe,
   input logic                       dev_p_oe,
   input logic                       ext_d_oe,
   input logic                       ext_p_oe,
   input logic [bpa_pkg::DATA_W-1:0] bus_d,
   input logic [bpa_pkg::LANES-1:0]  bus_p,
   input logic                       outside_master_request_two,
   input logic                       outside_master_request_three,
   input logic                       outside_master_grant_two,
   input logic                       outside_master_grant_three,
   input logic                       outside_data_grant_two,
   input logic                       outside_data_grant_three
);
   // ==========================================================
   // wire parity, judged whoever drives
   logic par_on;
   assign par_on = dev_p_oe | ext_p_oe;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   lane_zero_par_a: assert property (
      par_on |-> ^{bus_p[0], bus_d[7:0]})
      else $error("lane zero parity even");
   lane_one_par_a: assert property (
      par_on |-> ^{bus_p[1], bus_d[15:8]})
      else $error("lane one parity even");
   lane_two_par_a: assert property (
      par_on |-> ^{bus_p[2], bus_d[23:16]})
      else $error("lane two parity even");
   lane_three_par_a: assert property (
      par_on |-> ^{bus_p[3], bus_d[31:24]})
      else $error("lane three parity even");
   lane_four_par_a: assert property (
      par_on |-> ^{bus_p[4], bus_d[39:32]})
      else $error("lane four parity even");
   lane_five_par_a: assert property (
      par_on |-> ^{bus_p[5], bus_d[47:40]})
      else $error("lane five parity even");
   one_driver_a: assert property ((dev_d_oe == dev_p_oe)
      && (ext_d_oe == ext_p_oe) && !(dev_d_oe && ext_d_oe))
      else $error("parity not with data driver");

   // ==========================================================
   // arbitration
   grant_cause_a: assert property ($rose(outside_master_grant_two) |->
      $past(outside_master_request_two) && !$past(outside_master_grant_three))
      else $error("grant two without request");
   data_follows_a: assert property ($rose(outside_master_grant_three) |=>
      outside_data_grant_three) else $error("data grant three late");
   data_pair_a: assert property (outside_data_grant_two |->
      outside_master_grant_two) else $error("data grant two unpaired");
   one_owner_a: assert property (!(outside_master_grant_two
      && outside_master_grant_three) && !(outside_data_grant_two
      && outside_data_grant_three)) else $error("two masters granted");
   grant_hold_a: assert property (outside_master_grant_two
      && outside_master_request_two |=> outside_master_grant_two)
      else $error("grant two dropped while requested");
   grant_drop_a: assert property (outside_master_grant_three
      && !outside_master_request_three |=> !outside_master_grant_three
      && !outside_data_grant_three) else $error("grant three held");
endmodule : bpa_chk

// ### bus_parity_ext_arbitration_tb.sv
module bus_parity_ext_arbitration_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [63:0] WORDS [5] = '{64'h0, 64'hFFFF_FFFF_FFFF_FFFF,
      64'h0102_0408_1020_4080, 64'hA5A5_5A5A_0F0F_F0F0,
      64'h8000_0000_0000_0001};
   // ==========================================================
   // stimulus and observation
   bpa_bus_if bus_if ();
   logic                       clk = 1'h0;
   logic                       resetn = 1'h0;
   logic                       busy = 1'h0;
   logic                       want2 = 1'h0;
   logic                       want3 = 1'h0;
   logic                       dreq = 1'h0;
   logic                       dslv = 1'h0;
   logic [63:0]                ddat = 64'h0;
   logic                       ereq = 1'h0;
   logic [63:0]                edat = 64'h0;
   logic [1:0]                 owner;
   logic [bpa_pkg::CNT_W-1:0]  gcnt;
   logic [63:0]                drx;
   logic [63:0]                erx;
   logic                       drv;
   logic                       erv;
   logic                       dref;
   logic                       eg2;
   logic                       eg3;
   logic [5:0]                 dperr;
   logic [5:0]                 eperr;
   int                         num_errors = 0;
   int                         checks_done = 0;
   int                         tenures = 0;
   wire                        ag2 = bus_if.outside_master_grant_two;
   wire                        ag3 = bus_if.outside_master_grant_three;
   wire                        dg2 = bus_if.outside_data_grant_two;
   wire                        dg3 = bus_if.outside_data_grant_three;

   always #5 clk = ~clk;

   bpa_dev_end u_bpa_dev_end (.clk(clk), .resetn(resetn), .bus(bus_if),
      .internal_busy(busy), .drive_req(dreq), .drive_as_slave(dslv),
      .drive_data(ddat), .owner(owner), .grant_count(gcnt), .rx_data(drx),
      .rx_valid(drv), .parity_err(dperr), .drive_refused(dref));
   bpa_ext_end u_bpa_ext_end (.clk(clk), .resetn(resetn), .bus(bus_if),
      .want_two(want2), .want_three(want3), .drive_req(ereq),
      .drive_as_slave(1'h0), .drive_data(edat), .granted_two(eg2),
      .granted_three(eg3), .rx_data(erx), .rx_valid(erv), .parity_err(eperr));
   bpa_chk u_bpa_chk (.clk(clk), .resetn(resetn),
      .dev_d_oe(bus_if.dev_d_oe), .dev_p_oe(bus_if.dev_p_oe),
      .ext_d_oe(bus_if.ext_d_oe), .ext_p_oe(bus_if.ext_p_oe),
      .bus_d(bus_if.bus_d), .bus_p(bus_if.bus_p),
      .outside_master_request_two(bus_if.outside_master_request_two),
      .outside_master_request_three(bus_if.outside_master_request_three),
      .outside_master_grant_two(ag2), .outside_master_grant_three(ag3),
      .outside_data_grant_two(dg2), .outside_data_grant_three(dg3));

   // ==========================================================
   // helpers
   task automatic chk(input bit ok, input string msg);
      checks_done++;
      if (!ok) begin
         num_errors++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask : chk

   function automatic logic [5:0] odd_par(input logic [63:0] w);
      for (int i = 0; i < 6; i++) odd_par[i] = ~^w[8*i+:8];
   endfunction : odd_par

   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   // ==========================================================
   // scenarios
   // back-to-back words so a parity stage lagging its data shows up
   task automatic t_stream(input bit dev, input bit slv);
      logic [63:0] w;
      for (int i = 0; i <= 6; i++) begin
         @(posedge clk);
         if (dev) begin
            dreq <= (i < 5);
            dslv <= slv;
            ddat <= WORDS[i%5];
         end else begin
            ereq <= (i < 5);
            edat <= WORDS[i%5];
         end
         #1;
         // word launched one edge ago
         w = WORDS[(i+4)%5];
         if (i >= 1 && i <= 5) chk(bus_if.bus_d === w && bus_if.bus_p
            === odd_par(w), "bus word or parity");
         if (i >= 2 && dev) chk(erv === 1'h1 && erx === WORDS[i-2]
            && eperr === 6'h0, "device word not seen");
         if (i >= 2 && !dev) chk(drv === 1'h1 && drx === WORDS[i-2]
            && dperr === 6'h0, "outside word not seen");
         if (i == 6) chk(bus_if.dev_d_oe === 1'h0 && bus_if.ext_d_oe === 1'h0
            && bus_if.dev_p_oe === 1'h0, "bus not released");
      end
   endtask : t_stream

   task automatic t_grant_two();
      @(posedge clk);
      want2 <= 1'h1;
      // the outside end registers its request pin, so the grant
      // appears two edges after the want input rises
      repeat (2) @(posedge clk);
      #1;
      tenures++;
      chk(ag2 === 1'h1 && owner === 2'h2 && dg2 === 1'h0,
         "address grant");
      chk(gcnt === tenures[15:0], "tenure count");
      @(posedge clk);
      #1;
      chk(dg2 === 1'h1 && dg3 === 1'h0, "data grant two");
      @(posedge clk);
      #1;
      chk(eg2 === 1'h1 && eg3 === 1'h0, "outside end not granted");
      t_stream(1'h0, 1'h0);
      t_stream(1'h1, 1'h1);
      // device as master while the outside master owns the data bus
      @(posedge clk);
      dreq <= 1'h1;
      dslv <= 1'h0;
      @(posedge clk);
      dreq <= 1'h0;
      #1;
      chk(dref === 1'h1 && bus_if.dev_d_oe === 1'h0, "drive not refused");
      chk(ag2 === 1'h1 && dg2 === 1'h1, "grant lost while held");
      @(posedge clk);
      want2 <= 1'h0;
      repeat (2) @(posedge clk);
      #1;
      chk(ag2 === 1'h0 && dg2 === 1'h0 && owner === 2'h0, "grant kept");
   endtask : t_grant_two

   task automatic t_both();
      @(posedge clk);
      want2 <= 1'h1;
      want3 <= 1'h1;
      repeat (2) @(posedge clk);
      #1;
      tenures++;
      chk(ag3 === 1'h1 && ag2 === 1'h0 && owner === 2'h3,
         "turn of three");
      chk(gcnt === tenures[15:0], "tenure count");
      @(posedge clk);
      want3 <= 1'h0;
      repeat (2) @(posedge clk);
      #1;
      chk(ag2 === 1'h0 && ag3 === 1'h0 && dg3 === 1'h0, "idle cycle");
      @(posedge clk);
      #1;
      tenures++;
      chk(ag2 === 1'h1 && owner === 2'h2, "waiting master two");
      @(posedge clk);
      want2 <= 1'h0;
      repeat (2) @(posedge clk);
      #1;
      chk(ag2 === 1'h0 && dg2 === 1'h0 && owner === 2'h0, "grant kept");
   endtask : t_both

   task automatic t_busy();
      @(posedge clk);
      busy <= 1'h1;
      want3 <= 1'h1;
      repeat (4) @(posedge clk);
      #1;
      chk(ag3 === 1'h0 && ag2 === 1'h0, "grant while busy");
      @(posedge clk);
      busy <= 1'h0;
      @(posedge clk);
      #1;
      tenures++;
      chk(ag3 === 1'h1 && gcnt === tenures[15:0], "grant after busy");
      @(posedge clk);
      want3 <= 1'h0;
      @(posedge clk);
      #1;
      chk(eg3 === 1'h1 && eg2 === 1'h0, "outside end not granted three");
      @(posedge clk);
      #1;
      chk(ag3 === 1'h0 && dg3 === 1'h0, "grant three kept");
   endtask : t_busy

   // ==========================================================
   // main sequence and watchdog
   initial begin
      repeat (16) @(posedge clk);
      resetn <= 1'h1;
      @(posedge clk);
      #1;
      chk(ag2 === 1'h0 && ag3 === 1'h0 && owner === 2'h0
         && gcnt === 16'h0, "reset state");
      t_stream(1'h1, 1'h0);
      t_grant_two();
      t_both();
      t_busy();
      end_of_test();
   end

   // whole run is about 70 cycles, so this only trips on a hang
   initial begin
      repeat (2000) @(posedge clk);
      num_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      end_of_test();
   end
endmodule : bus_parity_ext_arbitration_tb
